// ---- dam_map.vh ----
// Register map, field positions and reset values of the DRAM address multiplexer
`ifndef DAM_MAP_VH
`define DAM_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define DAM_ADDR_W          28
`define DAM_OFS_MEMCFG      28'hffffc00
`define DAM_OFS_SDCTL       28'hffffc04
`define DAM_OFS_STATUS      28'hffffc08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DAM_MEMCFG_COLUMN_LINE8_SELECT_BIT 5
`define DAM_MEMCFG_L11_BIT  11
`define DAM_MEMCFG_L12_LSB  14
`define DAM_MEMCFG_L12_MSB  15
`define DAM_SDCTL_COLUMN_LOW_SELECT_BIT  6
`define DAM_SDCTL_SDRAM_ENABLE_BIT  15

// ----------------------------------------------------------------
// Line-12 select codes
// ----------------------------------------------------------------
`define DAM_L12_PA10        2'h0
`define DAM_L12_PA21        2'h1
`define DAM_L12_PA23        2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DAM_MEMCFG_RST      16'h0000
`define DAM_SDCTL_RST       16'h0000
`define DAM_MUX_RST         16'h0000

`endif

// ---- dam_line_mux.v ----
// Combinational row/column/plain selection for the multiplexed address lines
`timescale 1ns/1ns
`include "dam_map.vh"

module dam_line_mux (
    // Internal address and access kind
    input  wire [24:0] internal_addr_i,
    input  wire        dram_access_i,
    input  wire        row_phase_i,
    input  wire        port8_i,
    // Select bits from the registers
    input  wire        sdram_enable_i,
    input  wire        column_low_select_i,
    input  wire        column_line8_select_i,
    input  wire        line11_select_i,
    input  wire [1:0]  line12_select_i,
    // Selected line values
    output reg  [15:0] mux_next_o
);

    // Three-way pick used for line 12 in both phases
    function pick12;
        input [1:0]  sel;
        input [24:0] pa;
        begin
            case (sel)
                `DAM_L12_PA10: pick12 = pa[10];
                `DAM_L12_PA21: pick12 = pa[21];
                `DAM_L12_PA23: pick12 = pa[23];
                default:       pick12 = 1'b0; // Reserved code drives low
            endcase
        end
    endfunction

    // Wide-row parts put PA21 or PA23 on line 12 instead of PA10, so row-phase lines 8-10 change with it
    wire wide_row;
    assign wide_row = (line12_select_i != `DAM_L12_PA10);

    // Line selection
    always @* begin
        mux_next_o = 16'h0000;
        if (!dram_access_i) begin
            mux_next_o[12:0]  = internal_addr_i[13:1];
            mux_next_o[15:13] = internal_addr_i[16:14];
        end else if (row_phase_i) begin
            mux_next_o[0]   = internal_addr_i[11];
            mux_next_o[7:1] = internal_addr_i[18:12];
            mux_next_o[8]   = wide_row ? internal_addr_i[20] : internal_addr_i[10];
            mux_next_o[9]   = wide_row ? internal_addr_i[19] : internal_addr_i[9];
            mux_next_o[10]  = wide_row ? internal_addr_i[21] : internal_addr_i[19];
            mux_next_o[11]  = line11_select_i ? internal_addr_i[22] : internal_addr_i[20];
            mux_next_o[12]  = pick12(line12_select_i, internal_addr_i);
            mux_next_o[15:13] = internal_addr_i[24:22];
        end else begin
            mux_next_o[7:1] = internal_addr_i[8:2];
            // Byte-wide ports take PA0 low and push PA1 up to line 9
            if (port8_i) begin
                mux_next_o[0] = internal_addr_i[0];
                mux_next_o[9] = internal_addr_i[1];
            end else if (sdram_enable_i) begin
                mux_next_o[0] = column_low_select_i ? internal_addr_i[0] : internal_addr_i[1];
                mux_next_o[9] = internal_addr_i[10];
            end else begin
                mux_next_o[0] = internal_addr_i[1];
                mux_next_o[9] = internal_addr_i[10];
            end
            mux_next_o[8]  = column_line8_select_i ? internal_addr_i[1] : internal_addr_i[9];
            // Line 10 is SDRAM A10: held low so no auto-precharge is asked for
            mux_next_o[10] = sdram_enable_i ? 1'b0 : internal_addr_i[11];
            mux_next_o[11] = line11_select_i ? internal_addr_i[22] : internal_addr_i[20];
            mux_next_o[12] = pick12(line12_select_i, internal_addr_i);
            mux_next_o[15:13] = internal_addr_i[24:22];
        end
    end

endmodule // dam_line_mux

// ---- dam_top.v ----
// DRAM address multiplexer: Wishbone register slave and registered line outputs
//
// Function
// - SDRAM column phase, line 0 takes PA1 when column-low select is 0, else PA0.
// - Column phase, line 8 takes PA9 when line-8 select is 0, else PA1.
// - Line 11 takes PA20 when line-11 select is 0, else PA22.
// - Line 12 takes PA10, PA21 or PA23 for select codes 00, 01, 10.
// - SDRAM enable 0 selects ordinary column mapping, 1 the SDRAM column mapping.
// - Non-DRAM accesses put PA1-PA13 straight onto lines 0-12.
// - Byte-wide accesses use PA0 as the lowest column line and shift PA1 up.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
`include "dam_map.vh"

module dam_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [27:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Access from the CPU or display fetch side
    input  wire [24:0] internal_addr_i,
    input  wire        dram_access_i,
    input  wire        row_phase_i,
    input  wire        port8_i,
    // Multiplexed address lines
    output reg  [15:0] multiplexed_addr_o
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // Bus states, one-hot
    localparam [1:0]  ST_IDLE    = 2'b01;
    localparam [1:0]  ST_ACK     = 2'b10;
    // Reset images, sliced per byte lane below
    localparam [15:0] MEMCFG_RST = `DAM_MEMCFG_RST;
    localparam [15:0] SDCTL_RST  = `DAM_SDCTL_RST;

    reg  [15:0] memcfg_reg;
    reg  [15:0] sdctl_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    wire [15:0] mux_next;
    wire        req;
    wire        hit_memcfg;
    wire        hit_sdctl;
    wire        hit_status;
    wire        wr_go;
    wire        wr_memcfg;
    wire        wr_sdctl;
    wire        rd_go;
    wire        sdram_enable;
    wire        column_low_select;
    wire        column_line8_select;
    wire        line11_select;
    wire [1:0]  line12_select;

    // Word decode; the low address bits are ignored since each register is a whole word
    function is_at;
        input [27:0] adr;
        input [27:0] ofs;
        begin
            is_at = (adr[27:2] == ofs[27:2]);
        end
    endfunction

    assign req        = cyc_i & stb_i;
    assign hit_memcfg = is_at(adr_i, `DAM_OFS_MEMCFG);
    assign hit_sdctl  = is_at(adr_i, `DAM_OFS_SDCTL);
    assign hit_status = is_at(adr_i, `DAM_OFS_STATUS);
    // A write lands at the edge at which the master samples ack, once per request
    assign wr_go      = req & we_i & ack_o;
    assign wr_memcfg  = wr_go & hit_memcfg;
    assign wr_sdctl   = wr_go & hit_sdctl;
    // Read data is captured one edge earlier, so it stands together with ack
    assign rd_go      = req & ~we_i & ~ack_o;

    // ----------------------------------------------------------------
    // Register select fields
    // ----------------------------------------------------------------
    // Field wires named after what they steer on the lines
    assign sdram_enable        = sdctl_reg[`DAM_SDCTL_SDRAM_ENABLE_BIT];
    assign column_low_select   = sdctl_reg[`DAM_SDCTL_COLUMN_LOW_SELECT_BIT];
    assign column_line8_select = memcfg_reg[`DAM_MEMCFG_COLUMN_LINE8_SELECT_BIT];
    assign line11_select       = memcfg_reg[`DAM_MEMCFG_L11_BIT];
    assign line12_select       = memcfg_reg[`DAM_MEMCFG_L12_MSB:`DAM_MEMCFG_L12_LSB];

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // One wait state, then ack for one cycle; unmapped addresses are acked too so a stray
    // access never hangs the bus, reading zero and dropping writes
    always @* begin
        state_next = ST_IDLE;
        case (state_reg)
            ST_IDLE: begin
                if (req) begin
                    state_next = ST_ACK;
                end
            end
            ST_ACK: begin
                state_next = ST_IDLE; // Forces one idle edge between two acks
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State register
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Ack decoded from the state: it cannot outlive its single cycle
    always @* begin
        ack_o = (state_reg == ST_ACK);
    end

    // ----------------------------------------------------------------
    // Register writes, byte lanes 0 and 1 only
    // ----------------------------------------------------------------
    // Lanes 2 and 3 hold no storage, so writes on them are dropped quietly
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
            always @(posedge clk_i) begin
                if (rst_i) begin
                    memcfg_reg[lane*8 +: 8] <= MEMCFG_RST[lane*8 +: 8];
                    sdctl_reg[lane*8 +: 8]  <= SDCTL_RST[lane*8 +: 8];
                end else begin
                    if (wr_memcfg & sel_i[lane]) begin
                        memcfg_reg[lane*8 +: 8] <= dat_i[lane*8 +: 8];
                    end
                    if (wr_sdctl & sel_i[lane]) begin
                        sdctl_reg[lane*8 +: 8] <= dat_i[lane*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Read image of the addressed word; unmapped words read zero
    function [31:0] read_word;
        input        at_memcfg;
        input        at_sdctl;
        input        at_status;
        input [15:0] memcfg;
        input [15:0] sdctl;
        input [15:0] lines;
        begin
            read_word = 32'h00000000;
            if (at_memcfg) begin
                read_word = {16'h0000, memcfg};
            end else if (at_sdctl) begin
                read_word = {16'h0000, sdctl};
            end else if (at_status) begin
                read_word = {16'h0000, lines}; // Live line state for software
            end
        end
    endfunction

    // Captured on the same edge that raises ack, so data and ack line up
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (rd_go) begin
            dat_o <= read_word(hit_memcfg, hit_sdctl, hit_status, memcfg_reg, sdctl_reg, multiplexed_addr_o);
        end else begin
            dat_o <= 32'h00000000; // Zero outside the ack cycle
        end
    end

    // ----------------------------------------------------------------
    // Line selection
    // ----------------------------------------------------------------
    // Select bits come straight from the registers; a rewrite mid-access takes effect
    // on the next line update, so software should reprogram only while memory is idle
    dam_line_mux u_line_mux (
        .internal_addr_i       (internal_addr_i),
        .dram_access_i         (dram_access_i),
        .row_phase_i           (row_phase_i),
        .port8_i               (port8_i),
        .sdram_enable_i        (sdram_enable),
        .column_low_select_i   (column_low_select),
        .column_line8_select_i (column_line8_select),
        .line11_select_i       (line11_select),
        .line12_select_i       (line12_select),
        .mux_next_o            (mux_next)
    );

    // ----------------------------------------------------------------
    // Output lines
    // ----------------------------------------------------------------
    // Registered so the pins never glitch while the phase input changes; costs one cycle
    // of latency which the strobe timing logic must allow for
    always @(posedge clk_i) begin
        if (rst_i) begin
            multiplexed_addr_o <= `DAM_MUX_RST;
        end else begin
            multiplexed_addr_o <= mux_next;
        end
    end

endmodule // dam_top

// ---- dam_props.sv ----
// Port checker for the DRAM address multiplexer
`timescale 1ns/1ns
module dam_props (
    // Clock, reset and bus
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // Line path
    input wire [24:0] internal_addr_i,
    input wire        dram_access_i,
    input wire        row_phase_i,
    input wire        port8_i,
    input wire [15:0] multiplexed_addr_o
);
    // ----------------------------------------
    // Handshake and line mapping
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Antecedents skip the release edge, where the outputs still show reset
    sequence s_req; !rst_i && cyc_i && stb_i && !ack_o; endsequence
    sequence s_col; !rst_i && dram_access_i && !row_phase_i; endsequence
    // One wait cycle, then a single pulse
    a_ack_one_wait: assert property (s_req |=> ack_o) else $error("ack not one cycle after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
    a_row_lines: assert property (!rst_i && dram_access_i && row_phase_i |=>
        multiplexed_addr_o[7:1] == $past(internal_addr_i[18:12])) else $error("row lines 1-7 wrong");
    a_col_lines: assert property (s_col |=>
        multiplexed_addr_o[7:1] == $past(internal_addr_i[8:2])) else $error("column lines 1-7 wrong");
    a_plain_addr: assert property (!rst_i && !dram_access_i |=>
        multiplexed_addr_o[12:0] == $past(internal_addr_i[13:1])) else $error("plain address wrong");
    a_byte_low: assert property (s_col and port8_i |=>
        multiplexed_addr_o[0] == $past(internal_addr_i[0])) else $error("byte-wide low line wrong");
endmodule // dam_props

// ---- dam_sdram_model.sv ----
// Behavioural SDRAM pin model capturing the column address
`timescale 1ns/1ns
module dam_sdram_model (
    // Clock and phase
    input  wire        clk_i,
    input  wire        dram_access_i,
    input  wire        row_phase_i,
    // Lines from the multiplexer
    input  wire [15:0] multiplexed_addr_i,
    // Precharge request seen at column time
    output wire        auto_precharge_o
);
    reg        dram_reg = 1'b0;
    reg        row_reg = 1'b0;
    reg [15:0] col_reg = 16'h0;
    // Phase is delayed a cycle because the lines are registered
    always @(posedge clk_i) begin
        dram_reg <= dram_access_i;
        row_reg  <= row_phase_i;
        if (dram_reg && !row_reg) begin
            col_reg <= multiplexed_addr_i;
        end
    end
    // Line 10 lands on chip A10 for every size, the precharge flag
    assign auto_precharge_o = col_reg[10];
endmodule // dam_sdram_model

// ---- test_dam_top.sv ----
// Self-checking testbench of the DRAM address multiplexer
`timescale 1ns/1ns
`include "dam_map.vh"
module test_dam_top;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         cyc_i = 1'b0;
    reg         stb_i = 1'b0;
    reg         we_i = 1'b0;
    reg  [27:0] adr_i = 28'h0;
    reg  [31:0] dat_i = 32'h0;
    reg  [3:0]  sel = 4'h3;
    reg  [3:0]  bsel = 4'h3;
    reg  [24:0] pa = 25'h0;
    reg         dram = 1'b0;
    reg         row = 1'b0;
    reg         p8 = 1'b0;
    reg  [31:0] seed = 32'he21f60cb;
    reg  [31:0] rd;
    reg  [15:0] mc = 16'h0;
    reg  [15:0] sc = 16'h0;
    wire [31:0] dat_o;
    wire        ack_o;
    wire [15:0] mux;
    wire        ap;
    integer     errors = 0;
    integer     tests_run = 0;
    integer     i;
    integer     j;
    // ----------------------------------------
    // Design, far-side model and clock
    // ----------------------------------------
    dam_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .internal_addr_i(pa),
        .dram_access_i(dram), .row_phase_i(row), .port8_i(p8), .multiplexed_addr_o(mux));
    dam_sdram_model chip (.clk_i(clk_i), .dram_access_i(dram), .row_phase_i(row),
        .multiplexed_addr_i(mux), .auto_precharge_o(ap));
    always #20 clk_i = ~clk_i;
    function [31:0] nxt(input [31:0] x);
        nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Expected lines from the current selects; code 11 on line 12 gives 0
    function [15:0] exp_map(input [24:0] a, input d, input r, input b);
        reg [15:0] m;
        begin
            m[15:13] = a[24:22];
            m[12] = (mc[15:14] == 2'h0) ? a[10] : (mc[15:14] == 2'h1) ? a[21] : (mc[15:14] == 2'h2) ? a[23] : 1'b0;
            m[11] = mc[11] ? a[22] : a[20];
            m[10:8] = (mc[15:14] == 2'h0) ? {a[19], a[9], a[10]} : {a[21], a[19], a[20]};
            m[7:0] = {a[18:12], a[11]};
            if (!r) begin
                m[7:0] = {a[8:2], (b || (sc[15] && sc[6])) ? a[0] : a[1]};
                m[8] = mc[5] ? a[1] : a[9];
                m[9] = b ? a[1] : a[10];
                m[10] = sc[15] ? 1'b0 : a[11];
            end
            exp_map = d ? m : a[16:1];
        end
    endfunction
    task complete_run;
        begin
            $display("Checks %0d errors %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input [79:0] name, input [31:0] seen, input [31:0] want);
        begin
            tests_run = tests_run + 1;
            if (seen !== want) begin
                errors = errors + 1;
                $display("Error %0s expected %h seen %h", name, want, seen);
            end
        end
    endtask
    // Classic single cycle; the wait is bounded and a missing ack ends the run
    task wb(input w, input [27:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_i);
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i  <= w;
            adr_i <= a;
            sel   <= bsel;
            dat_i <= d;
            n = 0;
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (ack_o !== 1'b1 && n < 20);
            if (ack_o !== 1'b1) begin
                chk("ack", {31'h0, ack_o}, 32'h1);
                complete_run;
            end
            rd = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("mux_rst", {16'h0, mux}, 32'h0);
        wb(1'b0, `DAM_OFS_MEMCFG, 32'h0);
        chk("memcfg_rst", rd, {16'h0, `DAM_MEMCFG_RST});
        wb(1'b0, `DAM_OFS_SDCTL, 32'h0);
        chk("sdctl_rst", rd, {16'h0, `DAM_SDCTL_RST});
        wb(1'b0, 28'hffffc0c, 32'h0);
        chk("unmapped", rd, 32'h0);
        // Every line-12 code and every enable/low-select pair, random elsewhere
        for (i = 0; i < 16; i = i + 1) begin
            seed = nxt(seed);
            mc = {i[1:0], seed[13:0]};
            sc = {i[2], seed[30:23], i[3], seed[22:17]};
            wb(1'b1, `DAM_OFS_MEMCFG, {16'hffff, mc});
            wb(1'b1, `DAM_OFS_SDCTL, {seed[31:16], sc});
            wb(1'b0, `DAM_OFS_MEMCFG, 32'h0);
            chk("memcfg", rd, {16'h0, mc});
            wb(1'b0, `DAM_OFS_SDCTL, 32'h0);
            chk("sdctl", rd, {16'h0, sc});
            for (j = 0; j < 6; j = j + 1) begin
                seed = nxt(seed);
                @(posedge clk_i);
                pa <= seed[24:0];
                dram <= seed[25] | (j < 4);
                row <= j[0];
                p8 <= seed[27];
                @(posedge clk_i);
                @(negedge clk_i);
                chk("lines", {16'h0, mux}, {16'h0, exp_map(pa, dram, row, p8)});
                @(negedge clk_i);
                if (dram && !row && sc[15])
                    chk("precharge", {31'h0, ap}, 32'h0);
            end
            wb(1'b1, `DAM_OFS_STATUS, seed);
            wb(1'b0, `DAM_OFS_STATUS, 32'h0);
            chk("status", rd, {16'h0, exp_map(pa, dram, row, p8)});
        end
        // Byte lanes: only the enabled half of a word may change
        bsel = 4'h2;
        wb(1'b1, `DAM_OFS_MEMCFG, 32'h0);
        bsel = 4'h1;
        wb(1'b1, `DAM_OFS_SDCTL, 32'hffffffff);
        bsel = 4'h3;
        wb(1'b0, `DAM_OFS_MEMCFG, 32'h0);
        chk("memcfg_hi", rd, {16'h0, 8'h00, mc[7:0]});
        wb(1'b0, `DAM_OFS_SDCTL, 32'h0);
        chk("sdctl_lo", rd, {16'h0, sc[15:8], 8'hff});
        // Second reset in mid-run with live inputs: registers and lines return to zero
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("mux_rst2", {16'h0, mux}, 32'h0);
        wb(1'b0, `DAM_OFS_MEMCFG, 32'h0);
        chk("memcfg_rs2", rd, {16'h0, `DAM_MEMCFG_RST});
        wb(1'b0, `DAM_OFS_SDCTL, 32'h0);
        chk("sdctl_rs2", rd, {16'h0, `DAM_SDCTL_RST});
        complete_run;
    end
endmodule // test_dam_top
bind dam_top dam_props props (.*);
